/* shared/plb_pkg.sv */
// Shared constants for one configurable logic block: sizes, encodings, register map
package plb_pkg;
  // Array and cell sizes
  localparam int N_PT = 48;       // Logic product terms per block
  localparam int N_MC = 12;       // Macrocells and pin cells per block
  localparam int N_IN = 26;       // Matrix signals entering the block
  localparam int N_SP = 6;        // Special-purpose terms
  localparam int N_CL = 12;       // Term clusters
  localparam int CL_SZ = 4;       // Terms per cluster
  localparam int BANK_SZ = 6;     // Pin cells per enable bank
  localparam int N_GCLK = 4;      // Global clock pins
  localparam int N_DED = 4;       // Dedicated input pins
  localparam int N_EXT = 72;      // Pin and macrocell feedback of the other three blocks
  localparam int N_SRC = N_EXT + N_MC + N_MC + N_GCLK + N_DED;
  localparam int SEL_W = 7;       // Width of one matrix selector
  // Special term positions
  localparam int SP_OE0 = 0;      // First enable term; bank b owns SP_OE0+2b and +2b+1
  localparam int SP_AR = 4;       // Block-wide clear term
  localparam int SP_AP = 5;       // Block-wide set term
  // Cluster steering codes
  localparam logic [1:0] CD_OWN = 2'h0;   // Cluster c feeds macrocell c
  localparam logic [1:0] CD_UP = 2'h1;    // Cluster c feeds macrocell c+1
  localparam logic [1:0] CD_DOWN = 2'h2;  // Cluster c feeds macrocell c-1
  localparam logic [1:0] CD_NONE = 2'h3;  // Cluster unused
  // Pin driver modes
  localparam logic [1:0] OE_ON = 2'h0;    // Always driving
  localparam logic [1:0] OE_OFF = 2'h1;   // Never driving
  localparam logic [1:0] OE_T0 = 2'h2;    // First enable term of the bank
  localparam logic [1:0] OE_T1 = 2'h3;    // Second enable term of the bank
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;   // Software clear/set forcing
  localparam logic [ADDR_W-1:0] A_STATE = 4'h1;  // Macrocell flip-flop state
  localparam logic [ADDR_W-1:0] A_PINS = 4'h2;   // Synchronised pin levels
  localparam logic [ADDR_W-1:0] A_OE = 4'h3;     // Current pin driver enables
  localparam logic [ADDR_W-1:0] A_CLKS = 4'h4;   // Filtered global clock levels
  localparam int CTL_AR_BIT = 0;
  localparam int CTL_AP_BIT = 1;
  localparam logic [1:0] CTL_RST = 2'h0;
  localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;
endpackage

/* src/plb_block.sv */
// One configurable logic block: input selection, term array, allocator, macrocells, pin cells
`timescale 1ns/1ps
module plb_block #(
  parameter logic [plb_pkg::N_IN-1:0][plb_pkg::SEL_W-1:0] MX_SEL = '0,        // Source of each array input
  parameter logic [plb_pkg::N_PT-1:0][plb_pkg::N_IN-1:0] PT_TRUE = '0,        // True literals per term
  parameter logic [plb_pkg::N_PT-1:0][plb_pkg::N_IN-1:0] PT_COMP = '0,        // Complement literals per term
  parameter logic [plb_pkg::N_SP-1:0][plb_pkg::N_IN-1:0] SP_TRUE = '0,        // True literals, special terms
  parameter logic [plb_pkg::N_SP-1:0][plb_pkg::N_IN-1:0] SP_COMP = '1,        // Complement literals, special terms
  parameter logic [plb_pkg::N_CL-1:0][1:0] CL_DEST = '0,                       // Cluster steering
  parameter logic [plb_pkg::N_MC-1:0] MC_REG = '1,                             // 1 = registered
  parameter logic [plb_pkg::N_MC-1:0] MC_INV = '0,                             // 1 = inverted output
  parameter logic [plb_pkg::N_MC-1:0] MC_TFF = '0,                             // 1 = T flip-flop
  parameter logic [plb_pkg::N_MC-1:0][1:0] MC_CLK = '0,                        // Clock pin choice
  parameter logic [plb_pkg::N_MC-1:0][1:0] PIN_OE = '0,                        // Driver mode
  parameter logic [plb_pkg::N_MC-1:0] MC_BURIED = '0                           // 1 = pin is input only
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [plb_pkg::N_MC-1:0] pin_in,
  output logic [plb_pkg::N_MC-1:0] pin_out,
  output logic [plb_pkg::N_MC-1:0] pin_oe,
  input wire logic [plb_pkg::N_DED-1:0] ded_in,
  input wire logic [plb_pkg::N_GCLK-1:0] gclk_pin,
  input wire logic [plb_pkg::N_EXT-1:0] ext_fb,
  output logic [plb_pkg::N_MC-1:0] mc_fb,
  output logic [plb_pkg::N_MC-1:0] pin_fb,
  input wire logic [plb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [plb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [plb_pkg::DATA_W-1:0] reg_rdata
);
  import plb_pkg::*;

  // All block state in one record
  typedef struct packed {
    logic [N_MC-1:0] pin_s1;    // Pin synchroniser stages
    logic [N_MC-1:0] pin_s2;
    logic [N_MC-1:0] pin_s3;
    logic [N_DED-1:0] ded_s1;   // Dedicated input synchroniser stages
    logic [N_DED-1:0] ded_s2;
    logic [N_DED-1:0] ded_s3;
    logic [N_GCLK-1:0] clk_s1;  // Clock pin synchroniser stages
    logic [N_GCLK-1:0] clk_s2;
    logic [N_GCLK-1:0] clk_s3;
    logic [N_GCLK-1:0] clk_lvl; // Agreed clock pin level
    logic [N_MC-1:0] pin_lvl;   // Agreed pin level
    logic [N_DED-1:0] ded_lvl;  // Agreed dedicated input level
    logic [N_MC-1:0] mc_q;      // Macrocell flip-flops
    logic [N_MC-1:0] pin_out;   // Pin drive values
    logic [N_MC-1:0] pin_oe;    // Pin drive enables
    logic [N_MC-1:0] fb;        // Internal feedback
    logic [1:0] ctl;            // Software clear/set forcing
    logic [DATA_W-1:0] rdata;   // Read answer
  } plb_state_t;

  plb_state_t st_q;             // Registered state
  plb_state_t st_d;             // Next state
  logic [N_SRC-1:0] src;        // Everything the selection can reach
  logic [N_IN-1:0] arr_in;      // Selected array inputs
  logic [N_PT-1:0] pt;          // Logic terms
  logic [N_SP-1:0] sp;          // Special terms
  logic [N_MC-1:0] sum;         // Allocated sums
  logic [N_MC-1:0] mc_val;      // Macrocell value before polarity
  logic [N_MC-1:0] mc_outv;     // Macrocell value after polarity
  logic [N_GCLK-1:0] clk_rise;  // One-cycle rising edge per clock pin
  logic [N_MC-1:0] mc_edge;     // Selected clock edge per macrocell
  logic [N_MC-1:0] oe_v;        // Driver enables before registering
  logic clr_all;                // Block-wide clear
  logic set_all;                // Block-wide set
  logic [N_MC-1:0] on_mask;     // Pins always driving
  logic [N_MC-1:0] off_mask;    // Pins never driving

  // AND of chosen true and complemented literals
  function automatic logic pterm(
    input logic [N_IN-1:0] v,
    input logic [N_IN-1:0] t,
    input logic [N_IN-1:0] c
  );
    pterm = &((~t | v) & (~c | ~v));
  endfunction

  // Per-bit input filter: a new level counts only once stages two and three agree,
  // so a one-cycle glitch on a pin never reaches the array
  function automatic logic [N_MC-1:0] agree(
    input logic [N_MC-1:0] lvl,
    input logic [N_MC-1:0] s2,
    input logic [N_MC-1:0] s3
  );
    agree = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
  endfunction

  // Whole next-state computation
  always_comb
  begin
    st_d = st_q;
    // Three-stage sampling of pins; a change counts once stages two and three agree
    st_d.pin_s1 = pin_in;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_s3 = st_q.pin_s2;
    st_d.ded_s1 = ded_in;
    st_d.ded_s2 = st_q.ded_s1;
    st_d.ded_s3 = st_q.ded_s2;
    st_d.clk_s1 = gclk_pin;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    // Filtered levels of pins, dedicated inputs and clock pins; a rise is a freshly agreed high
    st_d.pin_lvl = agree(st_q.pin_lvl, st_q.pin_s2, st_q.pin_s3);
    st_d.ded_lvl = N_DED'(agree(N_MC'(st_q.ded_lvl), N_MC'(st_q.ded_s2), N_MC'(st_q.ded_s3)));
    st_d.clk_lvl = N_GCLK'(agree(N_MC'(st_q.clk_lvl), N_MC'(st_q.clk_s2), N_MC'(st_q.clk_s3)));
    clk_rise = st_d.clk_lvl & ~st_q.clk_lvl;
    // Selection pool: other blocks, own feedback, pins, clock pins as inputs, dedicated inputs
    src = {ext_fb, st_q.fb, st_q.pin_lvl, st_q.clk_lvl, st_q.ded_lvl};
    for (int i = 0; i < N_IN; i++)
    begin
      arr_in[i] = src[MX_SEL[i]];
    end
    // Term array
    for (int p = 0; p < N_PT; p++)
    begin
      pt[p] = pterm(arr_in, PT_TRUE[p], PT_COMP[p]);
    end
    for (int s = 0; s < N_SP; s++)
    begin
      sp[s] = pterm(arr_in, SP_TRUE[s], SP_COMP[s]);
    end
    // Allocator: each cluster goes to at most one neighbour, so a sum holds at most three clusters
    sum = '0;
    for (int m = 0; m < N_MC; m++)
    begin
      for (int c = 0; c < N_CL; c++)
      begin
        if ((c == m && CL_DEST[c] == CD_OWN) || (c == m - 1 && CL_DEST[c] == CD_UP) ||
            (c == m + 1 && CL_DEST[c] == CD_DOWN))
        begin
          sum[m] = sum[m] | (|pt[c*CL_SZ +: CL_SZ]);
        end
      end
    end
    // Shared clear and set, software forcing included; clear wins
    clr_all = sp[SP_AR] | st_q.ctl[CTL_AR_BIT];
    set_all = sp[SP_AP] | st_q.ctl[CTL_AP_BIT];
    on_mask = '0;
    off_mask = '0;
    for (int m = 0; m < N_MC; m++)
    begin
      mc_edge[m] = clk_rise[MC_CLK[m]];
      if (clr_all)
      begin
        st_d.mc_q[m] = 1'b0;
      end
      else if (set_all)
      begin
        st_d.mc_q[m] = 1'b1;
      end
      else if (mc_edge[m])
      begin
        // D loads the sum; T flips when the sum is one
        st_d.mc_q[m] = MC_TFF[m] ? (st_q.mc_q[m] ^ sum[m]) : sum[m];
      end
      mc_val[m] = MC_REG[m] ? st_q.mc_q[m] : sum[m];
      mc_outv[m] = mc_val[m] ^ MC_INV[m];
      // Driver mode; bank b may use only its own two enable terms
      unique case (PIN_OE[m])
        OE_ON: oe_v[m] = 1'b1;
        OE_OFF: oe_v[m] = 1'b0;
        OE_T0: oe_v[m] = sp[SP_OE0 + 2 * (m / BANK_SZ)];
        OE_T1: oe_v[m] = sp[SP_OE0 + 2 * (m / BANK_SZ) + 1];
      endcase
      if (MC_BURIED[m])
      begin
        oe_v[m] = 1'b0;
      end
      on_mask[m] = (PIN_OE[m] == OE_ON) && !MC_BURIED[m];
      off_mask[m] = (PIN_OE[m] == OE_OFF) || MC_BURIED[m];
    end
    // Feedback holds in either macrocell mode; pins and feedback share one value
    st_d.fb = mc_outv;
    st_d.pin_out = mc_outv;
    st_d.pin_oe = oe_v;
    // Register port: write forcing bits, read answers for one cycle
    if (reg_wr && reg_addr == A_CTRL)
    begin
      st_d.ctl = reg_wdata[1:0];
    end
    st_d.rdata = RD_IDLE;
    if (reg_rd)
    begin
      unique case (reg_addr)
        A_CTRL: st_d.rdata = {{(DATA_W-2){1'b0}}, st_q.ctl};
        A_STATE: st_d.rdata = {{(DATA_W-N_MC){1'b0}}, st_q.mc_q};
        A_PINS: st_d.rdata = {{(DATA_W-N_MC){1'b0}}, st_q.pin_lvl};
        A_OE: st_d.rdata = {{(DATA_W-N_MC){1'b0}}, st_q.pin_oe};
        A_CLKS: st_d.rdata = {{(DATA_W-N_GCLK){1'b0}}, st_q.clk_lvl};
        default: st_d.rdata = RD_IDLE;                                    // Unmapped reads as zero
      endcase
    end
  end

  // State register; configuration itself lives only in parameters
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.ctl <= CTL_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign pin_out = st_q.pin_out;
  assign pin_oe = st_q.pin_oe;
  assign mc_fb = st_q.fb;
  assign pin_fb = st_q.pin_lvl;
  assign reg_rdata = st_q.rdata;

  // Helper vectors for checks
  logic [N_MC-1:0] tog_req;     // T cells due to toggle
  logic [N_MC-1:0] load_req;    // D cells due to load
  assign tog_req = (clr_all || set_all) ? '0 : (mc_edge & MC_TFF & sum);
  assign load_req = (clr_all || set_all) ? '0 : (mc_edge & ~MC_TFF);

  a_clear_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clr_all |=> (st_q.mc_q == '0))
    else $error("clear term did not clear every flip-flop");
  a_set_all: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (set_all && !clr_all) |=> (st_q.mc_q == '1))
    else $error("set term did not set every flip-flop");
  a_hold_no_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!clr_all && !set_all && mc_edge == '0) |=> $stable(st_q.mc_q))
    else $error("flip-flop moved without a clock edge");
  a_t_toggle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tog_req != '0) |=> (((st_q.mc_q ^ $past(st_q.mc_q)) & $past(tog_req)) == $past(tog_req)))
    else $error("T flip-flop failed to toggle");
  a_d_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (load_req != '0) |=> ((st_q.mc_q & $past(load_req)) == ($past(sum) & $past(load_req))))
    else $error("D flip-flop failed to load its sum");
  a_oe_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rst_b |=> (((pin_oe & on_mask) == on_mask) && ((pin_oe & off_mask) == '0)))
    else $error("fixed driver mode not honoured");
  a_buried_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (pin_oe & MC_BURIED) == '0)
    else $error("buried macrocell drives its pin");
  a_fb_matches: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mc_fb == pin_out) &&
    (((mc_fb ^ MC_INV) & MC_REG) == ($past(st_q.mc_q) & MC_REG)))
    else $error("feedback differs from pin value");
  a_clk_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_rise != '0) |=> ((st_q.clk_lvl & $past(clk_rise)) == $past(clk_rise)))
    else $error("clock edge without agreed high level");
  a_read_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !reg_rd |=> (reg_rdata == RD_IDLE))
    else $error("read data present without a read");

  // Filtered inputs move only where stages two and three agreed one edge before
  a_pin_agree: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((st_q.pin_lvl ^ $past(st_q.pin_lvl)) & ($past(st_q.pin_s2) ^ $past(st_q.pin_s3))) == '0)
    else $error("pin level moved before its stages agreed");
  a_ded_agree: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((st_q.ded_lvl ^ $past(st_q.ded_lvl)) & ($past(st_q.ded_s2) ^ $past(st_q.ded_s3))) == '0)
    else $error("dedicated input level moved before its stages agreed");

  // Combinational cells hand the sum on with polarity applied, one register stage later
  // Reset is sampled in the antecedent so the release edge starts no attempt
  a_comb_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rst_b |=> (((mc_fb ^ MC_INV) & ~MC_REG) == ($past(sum) & ~MC_REG)))
    else $error("combinational cell does not follow its sum");

  // Register port: control writes land, reads show the state of the previous cycle
  // Unmapped places answer with the idle word
  a_ctl_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == A_CTRL) |=> (st_q.ctl == $past(reg_wdata[1:0])))
    else $error("control write did not land");
  a_state_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == A_STATE) |=> (reg_rdata[N_MC-1:0] == $past(st_q.mc_q)))
    else $error("state read does not show the flip-flops");
  a_ctl_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == A_CTRL) |=> (reg_rdata == {{(DATA_W-2){1'b0}}, $past(st_q.ctl)}))
    else $error("control read does not show the forcing bits");
  a_unmapped_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && reg_addr > A_CLKS) |=> (reg_rdata == RD_IDLE))
    else $error("unmapped read returned data");
endmodule

/* verification/plb_board.sv */
// Board-side model of the logic driving and sensing the twelve pins of one block
`timescale 1ns/1ps
module plb_board (
  input wire logic sys_clk,
  input wire logic [plb_pkg::N_MC-1:0] pin_out,
  input wire logic [plb_pkg::N_MC-1:0] pin_oe,
  input wire logic [plb_pkg::N_MC-1:0] drv_val,
  input wire logic [plb_pkg::N_MC-1:0] drv_en,
  output logic [plb_pkg::N_MC-1:0] pin_in
);
  import plb_pkg::*;
  // Last driven level, so a released pin shows its inverse and never a stale copy
  logic [N_MC-1:0] last_q = '0;
  // Wire level: the block wins where it drives, then the board, else the inverse of the last driven level
  always_comb
  begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & ~last_q);
  end
  // Remember the level only while someone drives the pin
  always @(posedge sys_clk)
  begin
    last_q <= ((pin_oe | drv_en) & pin_in) | (~(pin_oe | drv_en) & last_q);
  end
endmodule

/* verification/plb_block_bench.sv */
// Self-checking bench for one logic block with a fixed test configuration
`timescale 1ns/1ps
module plb_block_bench;
  import plb_pkg::*;
  logic sys_clk, rst_b, reg_wr, reg_rd;
  logic [N_MC-1:0] pin_in, pin_out, pin_oe, mc_fb, pin_fb, drv_val, drv_en;
  logic [N_DED-1:0] ded_in;
  logic [N_GCLK-1:0] gclk_pin;
  logic [N_EXT-1:0] ext_fb;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  int mismatches, num_checks;
  // Used terms: 0 ded0, 4 ded1, 8 ded2, 12 ext5, 20 ext4; unused ones carry both literals
  function automatic logic [N_PT-1:0][N_IN-1:0] pt_rows(input logic tru);
    pt_rows = '1;
    pt_rows[0] = tru ? 26'h0000001 : 26'h0000000;
    pt_rows[4] = tru ? 26'h0000002 : 26'h0000000;
    pt_rows[8] = tru ? 26'h0000004 : 26'h0000000;
    pt_rows[12] = tru ? 26'h2000000 : 26'h0000000;
    pt_rows[20] = tru ? 26'h1000000 : 26'h0000000;
  endfunction
  // Special terms: bank 0 enable ext2, bank 1 enable ext3, clear ext0, set ext1
  function automatic logic [N_SP-1:0][N_IN-1:0] sp_rows(input logic tru);
    sp_rows = '1;
    sp_rows[0] = tru ? 26'h0400000 : 26'h0000000;
    sp_rows[2] = tru ? 26'h0800000 : 26'h0000000;
    sp_rows[4] = tru ? 26'h0100000 : 26'h0000000;
    sp_rows[5] = tru ? 26'h0200000 : 26'h0000000;
  endfunction
  // Inputs 0..19 take dedicated, clock and pin levels; 20..25 take ext_fb[5:0]
  function automatic logic [N_IN-1:0][SEL_W-1:0] mx_rows();
    mx_rows = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      mx_rows[i] = SEL_W'((i < 20) ? i : i + 12);
    end
  endfunction
  plb_block #(.MX_SEL(mx_rows()), .PT_TRUE(pt_rows(1'b1)), .PT_COMP(pt_rows(1'b0)), .SP_TRUE(sp_rows(1'b1)),
    .SP_COMP(sp_rows(1'b0)), .CL_DEST(24'h000840), .MC_REG(12'hfeb), .MC_INV(12'h004), .MC_TFF(12'h002),
    .MC_CLK(24'h000004), .PIN_OE(24'h559524), .MC_BURIED(12'h008)) plb_block_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ded_in(ded_in),
    .gclk_pin(gclk_pin), .ext_fb(ext_fb), .mc_fb(mc_fb), .pin_fb(pin_fb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  plb_board plb_board_i (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val),
    .drv_en(drv_en), .pin_in(pin_in));
  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Compare one value and count it
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Board drive pattern for the pins that the block leaves free
  task automatic board(input logic [N_MC-1:0] v, input logic [N_MC-1:0] e);
    drv_val <= v;
    drv_en <= e;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is only valid in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
    @(posedge sys_clk);
  endtask
  // Clock pin pulse long enough to pass the pin synchroniser
  task automatic pulse(input int k);
    @(posedge sys_clk);
    gclk_pin[k] <= 1'b1;
    tick(4);
    gclk_pin[k] <= 1'b0;
    tick(6);
  endtask
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, mismatches);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ded_in = '0;
    gclk_pin = '0;
    ext_fb = '0;
    drv_val = '0;
    drv_en = '0;
    mismatches = 0;
    num_checks = 0;
    tick(10);
    rst_b <= 1'b1;
    tick(8);
    rd(A_STATE, 16'h0feb, 16'h0000); // cleared flops
    rd(4'h7, 16'hffff, 16'h0000); // unmapped reads zero
    chk({4'h0, pin_oe}, 16'h0001); // driver modes and buried pin
    chk({4'h0, mc_fb & 12'h014}, 16'h0004); // inverted comb feedback
    done("reset");
    ded_in[0] <= 1'b1;
    tick(8);
    rd(A_STATE, 16'h0feb, 16'h0000); // no edge no capture
    pulse(0);
    rd(A_STATE, 16'h0feb, 16'h0001); // D load
    chk({4'h0, pin_out & 12'h001}, 16'h0001); // registered output
    ded_in[0] <= 1'b0;
    pulse(0);
    rd(A_STATE, 16'h0feb, 16'h0000); // D load zero
    done("dflop");
    ded_in[1] <= 1'b1;
    pulse(0);
    rd(A_STATE, 16'h0feb, 16'h0000); // other clock ignored
    pulse(1);
    rd(A_STATE, 16'h0feb, 16'h0002); // toggle up
    pulse(1);
    rd(A_STATE, 16'h0feb, 16'h0000); // toggle down
    pulse(1);
    ded_in[1] <= 1'b0;
    pulse(1);
    rd(A_STATE, 16'h0feb, 16'h0002); // hold on zero
    done("tflop");
    ext_fb[1] <= 1'b1;
    tick(4);
    rd(A_STATE, 16'h0feb, 16'h0feb); // shared set
    ext_fb[0] <= 1'b1;
    tick(4);
    rd(A_STATE, 16'h0feb, 16'h0000); // clear beats set
    ext_fb[1:0] <= 2'h0;
    wr(A_CTRL, 16'h0002);
    tick(2);
    rd(A_STATE, 16'h0feb, 16'h0feb); // forced set
    wr(A_CTRL, 16'h0003);
    rd(A_CTRL, 16'hffff, 16'h0003); // control readback
    rd(A_STATE, 16'h0feb, 16'h0000); // forced clear wins
    wr(A_CTRL, 16'h0000);
    wr(A_STATE, 16'hffff);
    rd(A_STATE, 16'h0feb, 16'h0000); // read-only place unchanged
    done("clearset");
    ext_fb[2] <= 1'b1;
    tick(8);
    chk({4'h0, pin_oe}, 16'h0005); // bank 0 term enable
    rd(A_OE, 16'h0fff, 16'h0005); // enables readback
    ext_fb[3:2] <= 2'h2;
    tick(8);
    chk({4'h0, pin_oe}, 16'h0081); // bank 1 own term
    ext_fb[3] <= 1'b0;
    board(12'h00a, 12'h00a);
    tick(8);
    chk({4'h0, pin_fb & 12'h00a}, 16'h000a); // pin feedback incl buried pin
    rd(A_PINS, 16'h000a, 16'h000a); // synced pins readback
    done("pins");
    ded_in[2] <= 1'b1;
    ext_fb[5] <= 1'b1;
    tick(8);
    chk({4'h0, pin_out & 12'h014}, 16'h0010); // lower neighbour cluster
    ext_fb[5:4] <= 2'h1;
    tick(8);
    chk({4'h0, pin_out & 12'h014}, 16'h0010); // upper neighbour cluster
    ext_fb[4] <= 1'b0;
    tick(8);
    chk({4'h0, pin_out & 12'h014}, 16'h0000); // comb inverted output
    chk({4'h0, mc_fb & 12'h014}, 16'h0000); // comb feedback
    gclk_pin[2] <= 1'b1;
    tick(8);
    rd(A_CLKS, 16'h000f, 16'h0004); // clock pin as level
    gclk_pin <= 4'ha;
    board(12'h5a4, 12'hffe);
    done("logic");
    tick(8);
    rd(A_CLKS, 16'h000f, 16'h000a); // two clock pins as levels
    rd(A_PINS, 16'h0fff, 16'h05a4); // board levels on free pins
    board(12'h000, 12'h000);
    tick(8);
    rd(A_PINS, 16'h0ffe, 16'h0a5a); // released pins show inverse level
    done("board");
    rst_b <= 1'b0;
    tick(2);
    chk({4'h0, pin_oe}, 16'h0000); // reset drops every driver
    chk({4'h0, mc_fb}, 16'h0000); // reset clears feedback
    rst_b <= 1'b1;
    tick(8);
    rd(A_PINS, 16'h0ffe, 16'h0a5a); // pins refiltered after reset
    rd(A_CLKS, 16'h000f, 16'h000a); // clock levels refiltered
    done("rerst");
    end_sim();
  end
endmodule
